// File: cmp_irq_pkg.sv
// Purpose: constants and types for the comparator interrupt enable block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   offsets are word indices; byte address is four times the index
package cmp_irq_pkg;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_POWER    = 8'h4C; // power enables
  localparam logic [7:0] OFF_POLARITY = 8'h4D; // transition polarity
  localparam logic [7:0] OFF_FLAGS    = 8'h4E; // flags, clear on read
  localparam logic [7:0] OFF_MASK     = 8'h4F; // comparator_irq_mask
  localparam logic [7:0] OFF_STATUS   = 8'h50; // sticky event status
  localparam logic [7:0] OFF_IRQMSK   = 8'h54; // status interrupt mask

  // --------------------------------------------------------------
  // field layout and reset values
  // --------------------------------------------------------------
  localparam int         NUM_CMP       = 3;
  localparam int         LEVEL_LSB     = 4;
  localparam logic [2:0] POWER_RST     = 3'h0;
  localparam logic [2:0] POLARITY_RST  = 3'h7;
  localparam logic [2:0] MASK_RST      = 3'h0;
  localparam logic [2:0] FLAGS_RST     = 3'h0;
  localparam logic [2:0] STATUS_RST    = 3'h0;
  localparam logic [2:0] IRQMSK_RST    = 3'h0;

  // status bit positions
  localparam int ST_LATCH   = 0; // an enabled transition was latched
  localparam int ST_DROP    = 1; // a masked transition was dropped
  localparam int ST_PWRCLR  = 2; // a powerdown cleared a pending flag

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [2:0] level;  // live comparator outputs
  } cmp_in_t;

  typedef struct packed {
    logic [2:0] power;     // power enables toward comparators
    logic [2:0] polarity;  // transition polarity toward comparators
  } cmp_ctl_t;

endpackage : cmp_irq_pkg

// File: comparator_interrupt_enable.sv
// Purpose: interrupt enable, edge latching and register file for three
//          comparators
// Assumes: comparator outputs synchronous to pclk
// Notes:   zero wait-state APB slave, unmapped reads give zero
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module comparator_interrupt_enable (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire cmp_irq_pkg::apb_req_t  apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // comparator unit
  input  wire cmp_irq_pkg::cmp_in_t   cmp_in,
  output cmp_irq_pkg::cmp_ctl_t       cmp_ctl,
  // interrupts
  output logic                        cmp_irq,
  output logic                        status_irq
);
  import cmp_irq_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [2:0]  power_r,    power_nxt;
  logic [2:0]  polarity_r, polarity_nxt;
  logic [2:0]  mask_r,     mask_nxt;
  logic [2:0]  flags_r,    flags_nxt;
  logic [2:0]  status_r,   status_nxt;
  logic [2:0]  irqmsk_r,   irqmsk_nxt;
  logic [2:0]  level_q_r;
  logic [31:0] prdata_r,   prdata_nxt;
  logic        pready_r;
  logic        pslverr_r;
  logic        cmp_irq_r;
  logic        status_irq_r;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  wire        setup   = apb_req.psel & ~apb_req.penable;
  wire        access  = apb_req.psel &  apb_req.penable;
  wire        wr      = access & apb_req.pwrite;
  wire        rd      = access & ~apb_req.pwrite;
  // register index from an aligned byte address
  wire [7:0]  addr    = apb_req.paddr[9:2];
  wire        word_ok = apb_req.paddr[1:0] == 2'h0;
  wire [2:0]  wdat    = apb_req.pwdata[2:0];
  wire        hit_pwr = word_ok & (addr == OFF_POWER);
  wire        hit_pol = word_ok & (addr == OFF_POLARITY);
  wire        hit_flg = word_ok & (addr == OFF_FLAGS);
  wire        hit_msk = word_ok & (addr == OFF_MASK);
  wire        hit_st  = word_ok & (addr == OFF_STATUS);
  wire        hit_im  = word_ok & (addr == OFF_IRQMSK);
  wire        mapped  = hit_pwr | hit_pol | hit_flg | hit_msk
                        | hit_st | hit_im;
  wire [2:0]  level   = cmp_in.level;

  // live levels shown in bits 6-4 of the power, polarity, flags and mask registers
  wire [31:0] level_word = {25'h0000000, level, 4'h0};

  // --------------------------------------------------------------
  // per-comparator edge detection and flag logic
  // --------------------------------------------------------------
  logic [2:0] edge_hit;
  logic [2:0] latch_ev;
  logic [2:0] drop_ev;
  logic [2:0] pwrclr_ev;
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      // chosen edge of this comparator output
      assign edge_hit[g] = polarity_r[g]
                           ? ( level[g] & ~level_q_r[g])
                           : (~level[g] &  level_q_r[g]);
      assign latch_ev[g]  = edge_hit[g] & mask_r[g] & power_r[g];
      assign drop_ev[g]   = edge_hit[g] & ~mask_r[g];
      assign pwrclr_ev[g] = wr & hit_pwr & ~wdat[g] & flags_r[g];
    end
  endgenerate

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  wire        flag_rd  = rd & hit_flg;
  wire [2:0]  new_ev   = {|pwrclr_ev, |drop_ev, |latch_ev};
  wire [2:0]  st_clr   = (wr & hit_st) ? wdat : 3'h0;
  wire [2:0]  pwr_down = (wr & hit_pwr) ? ~wdat : 3'h0;

  always_comb begin
    power_nxt    = (wr & hit_pwr) ? wdat : power_r;
    polarity_nxt = (wr & hit_pol) ? wdat : polarity_r;
    // reserved and level bits of the write are dropped
    mask_nxt     = (wr & hit_msk) ? wdat : mask_r;
    irqmsk_nxt   = (wr & hit_im)  ? wdat : irqmsk_r;
    // read clears all, a same-cycle event still sets
    flags_nxt    = ((flag_rd ? 3'h0 : flags_r) & ~pwr_down)
                   | latch_ev;
    // write one to clear, new events win
    status_nxt   = (status_r & ~st_clr) | new_ev;
    case (1'b1)
      hit_pwr: prdata_nxt = level_word | {29'h0, power_r};
      hit_pol: prdata_nxt = level_word | {29'h0, polarity_r};
      hit_flg: prdata_nxt = level_word | {29'h0, flags_r};
      hit_msk: prdata_nxt = level_word | {29'h0, mask_r};
      hit_st:  prdata_nxt = {29'h0, status_r};
      hit_im:  prdata_nxt = {29'h0, irqmsk_r};
      default: prdata_nxt = 32'h0;
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_r    <= POWER_RST;
      polarity_r <= POLARITY_RST;
      mask_r     <= MASK_RST;
      flags_r    <= FLAGS_RST;
      status_r   <= STATUS_RST;
      irqmsk_r   <= IRQMSK_RST;
    end else begin
      power_r    <= power_nxt;
      polarity_r <= polarity_nxt;
      mask_r     <= mask_nxt;
      flags_r    <= flags_nxt;
      status_r   <= status_nxt;
      irqmsk_r   <= irqmsk_nxt;
    end
  end

  // previous comparator level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q_r <= 3'h0;
    end else begin
      level_q_r <= level;
    end
  end

  // read data captured in setup, ready and error in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= setup ? prdata_nxt : prdata_r;
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
    end
  end

  // interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_irq_r    <= 1'b0;
      status_irq_r <= 1'b0;
    end else begin
      cmp_irq_r    <= |flags_nxt;
      status_irq_r <= |(status_nxt & irqmsk_nxt);
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign cmp_ctl.power    = power_r;
  assign cmp_ctl.polarity = polarity_r;
  assign cmp_irq          = cmp_irq_r;
  assign status_irq       = status_irq_r;

endmodule : comparator_interrupt_enable

// File: cmp_irq_asserts.sv
// Purpose: port assertions for comparator_interrupt_enable
// Assumes: zero wait-state apb, one clock
// Notes:   enable bits mirrored from completed writes
`timescale 1ns/1ps
module cmp_irq_asserts (
  // clock, reset, apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire cmp_irq_pkg::apb_req_t apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  // comparator side
  input wire cmp_irq_pkg::cmp_in_t  cmp_in,
  input wire cmp_irq_pkg::cmp_ctl_t cmp_ctl,
  input wire logic                  cmp_irq
);
  import cmp_irq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed transfers
  wire logic acc   = apb_req.psel & apb_req.penable & pready;
  wire logic rd    = acc & !apb_req.pwrite;
  wire logic rd_fl = rd & (apb_req.paddr == {OFF_FLAGS, 2'h0});
  logic [2:0] mask_r;
  // mirror of the enable bits
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) mask_r <= 3'h0;
    else if (acc & apb_req.pwrite & (apb_req.paddr == {OFF_MASK, 2'h0}))
      mask_r <= apb_req.pwdata[2:0];
  a_ready_next: assert property (apb_req.psel & !apb_req.penable
    |=> pready) else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_mask_back: assert property (rd & (apb_req.paddr == {OFF_MASK, 2'h0})
    |-> prdata[2:0] == mask_r) else $error("enable bits read wrong");
  a_level_read: assert property (rd & (apb_req.paddr[9:4] == 6'h13)
    & (apb_req.paddr[1:0] == 2'h0)
    |-> prdata[7:3] == {1'b0, $past(cmp_in.level), 1'b0})
    else $error("level or reserved bits read wrong");
  a_reset_masked: assert property ($rose(presetn)
    |-> cmp_ctl == 6'h07 && !cmp_irq) else $error("bad state after reset");
  a_irq_cause: assert property ($rose(cmp_irq)
    |-> |($past(mask_r) & $past(cmp_ctl.power)
    & ($past(cmp_in.level) ^ $past(cmp_in.level, 2))
    & ~($past(cmp_in.level) ^ $past(cmp_ctl.polarity))))
    else $error("interrupt without enabled transition");
  a_flag_clear: assert property (rd_fl & $stable(cmp_in.level)
    |=> !cmp_irq) else $error("flag read did not clear");
  a_irq_hold: assert property ($fell(cmp_irq)
    |-> $past(rd_fl) || cmp_ctl.power != 3'h7)
    else $error("interrupt dropped without cause");
endmodule : cmp_irq_asserts

bind comparator_interrupt_enable cmp_irq_asserts cmp_irq_asserts_i (.pclk,
  .presetn, .apb_req, .prdata, .pready, .cmp_in, .cmp_ctl, .cmp_irq);

// File: tb_comparator_interrupt_enable.sv
// Purpose: self-checking bench for comparator_interrupt_enable
// Assumes: zero wait-state apb slave
// Notes:   reads queue their expected word for the monitor
`timescale 1ns/1ps
module tb_comparator_interrupt_enable;
  import cmp_irq_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  apb_req_t    req = '0;
  cmp_in_t     cmp_in = '0;
  cmp_ctl_t    cmp_ctl;
  logic [31:0] prdata;
  logic        pready, pslverr, cmp_irq, status_irq;
  logic [31:0] seed = 32'h5723;
  logic [31:0] expq[$];
  int          bad_count = 0;
  int          checked = 0;
  always #12.5 pclk = ~pclk;
  comparator_interrupt_enable comparator_interrupt_enable_i (.pclk, .presetn,
    .apb_req(req), .prdata, .pready, .pslverr, .cmp_in, .cmp_ctl, .cmp_irq,
    .status_irq);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // monitor: completed reads take the oldest note
  always @(negedge pclk)
    if (req.psel & req.penable & pready === 1'b1) begin
      if (!req.pwrite)
        chk("prdata", expq.size() ? expq.pop_front() : 'x, prdata);
      chk("pslverr", 32'(!(req.paddr[9:2] inside {OFF_POWER, OFF_POLARITY,
        OFF_FLAGS, OFF_MASK, OFF_STATUS, OFF_IRQMSK})), 32'(pslverr));
    end
  // one apb transfer, held until pready
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, {a, 2'h0}, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(negedge pclk); while (pready !== 1'b1 && ++n < 8);
    if (n == 8) begin
      bad_count++;
      finish_test();
    end
    @(posedge pclk);
    req <= '0;
  endtask : apb
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic lvl(logic [2:0] v);
    @(posedge pclk);
    cmp_in <= v;
    @(posedge pclk);
  endtask : lvl
  task automatic irq(logic ci, logic si);
    @(negedge pclk);
    chk("cmp_irq", 32'(ci), 32'(cmp_irq));
    chk("status_irq", 32'(si), 32'(status_irq));
  endtask : irq
  initial begin
    logic [2:0] l;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    seed = xs(seed);
    l = seed[2:0];
    cmp_in <= l;
    rd(OFF_POWER, 32'({l, 4'h0}));
    rd(OFF_POLARITY, 32'({l, 4'h7}));
    rd(OFF_MASK, 32'({l, 4'h0}));
    rd(8'h60, 32'h0);
    seed = xs(seed);
    apb(1'b1, OFF_MASK, seed);
    rd(OFF_MASK, 32'({l, 1'b0, seed[2:0]}));
    $display("test reset and readback done");
    apb(1'b1, OFF_MASK, 32'h0);
    apb(1'b1, OFF_POWER, 32'h7);
    apb(1'b1, OFF_STATUS, 32'h7);
    lvl(3'h0);
    lvl(3'h7);
    apb(1'b1, OFF_MASK, 32'h7);
    irq(1'b0, 1'b0);
    rd(OFF_FLAGS, 32'h70);
    rd(OFF_STATUS, 32'h2);
    apb(1'b1, OFF_IRQMSK, 32'h2);
    irq(1'b0, 1'b1);
    apb(1'b1, OFF_STATUS, 32'h2);
    irq(1'b0, 1'b0);
    $display("test masked edges done");
    apb(1'b1, OFF_MASK, 32'h0);
    apb(1'b1, OFF_POLARITY, 32'h5);
    apb(1'b1, OFF_MASK, 32'h7);
    lvl(3'h0);
    irq(1'b1, 1'b0);
    rd(OFF_FLAGS, 32'h2);
    rd(OFF_FLAGS, 32'h0);
    irq(1'b0, 1'b0);
    lvl(3'h7);
    apb(1'b1, OFF_POWER, 32'h6);
    rd(OFF_FLAGS, 32'h74);
    $display("test polarity and clear done");
    finish_test();
  end
endmodule : tb_comparator_interrupt_enable
